// File: hdl/sac_adc_control.sv
// Register access over APB was decided locally.
`timescale 1ns/1ns
module sac_adc_control import sac_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Analog front end
	input wire logic compHigh,
	output logic [CHAN_N-1:0] chanSel,
	output logic sampleHold,
	output logic [RES_W-1:0] dacCode,
	output logic moduleAwake,
	// External trigger pin
	input wire logic extTrigger,
	// Completion interrupt request
	output logic doneIrq
);

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	logic pready_r;
	logic pslverr_r;
	logic [DATA_W-1:0] prdata_r;
	sac_mode_t mode_r;
	logic flag_r;
	logic [7:0] ckstp_r;
	logic edgeSel_r;
	logic irqReq_r;
	logic irqEn_r;
	logic doneIrq_r;
	logic trigPrev_r;
	logic [CHAN_N-1:0] chanSel_r;
	logic [7:0] resHigh_r;
	logic [1:0] resLow_r;
	logic engBusy;
	logic finish;
	logic [RES_W-1:0] finalCode;
	sac_ana_t ana;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------

	// Address match per register
	wire logic selResH = (paddr == addrOf(IDX_RES_HIGH));
	wire logic selResL = (paddr == addrOf(IDX_RES_LOW));
	wire logic selMode = (paddr == addrOf(IDX_MODE));
	wire logic selStart = (paddr == addrOf(IDX_START));
	wire logic selEdge = (paddr == addrOf(IDX_TRIG_EDGE));
	wire logic selIrq = (paddr == addrOf(IDX_DONE_IRQ));
	wire logic selCkstp = (paddr == addrOf(IDX_CKSTP1));
	wire logic mapped = selResH | selResL | selMode | selStart | selEdge | selIrq | selCkstp;

	// One wait state, then completion
	wire logic apbAccess = psel & penable;
	wire logic apbLast = apbAccess & pready_r;
	wire logic wrEn = apbLast & pwrite & mapped;
	wire logic rdLoad = apbAccess & ~pready_r & ~pwrite;

	// Standby gates mode and start register writes
	wire logic standby = ~ckstp_r[CKSTP_ADC_BIT];
	wire logic modeWr = wrEn & selMode & ~standby;
	wire logic startWr = wrEn & selStart & ~standby;

	// ----------------------------------------
	// Start, stop and trigger
	// ----------------------------------------

	// Edge of the trigger pin chosen by the edge-select bit
	wire logic trigRise = extTrigger & ~trigPrev_r;
	wire logic trigFall = ~extTrigger & trigPrev_r;
	wire logic trigEdge = edgeSel_r ? trigRise : trigFall;
	wire logic trigStart = mode_r.trigEn & trigEdge & ~flag_r & ~standby;
	wire logic swStart = startWr & pwdata[START_FLAG_BIT] & ~flag_r;
	wire logic swStop = startWr & ~pwdata[START_FLAG_BIT] & flag_r;
	wire logic convStart = swStart | trigStart;

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	wire logic [7:0] modeRead = {mode_r.speed, mode_r.trigEn, 2'b00, mode_r.chan} | MODE_FIXED_ONES;
	wire logic [7:0] startRead = {flag_r, 7'h00} | START_FIXED_ONES;
	wire logic [7:0] rdMux = selResH ? resHigh_r :
		selResL ? {resLow_r, 6'h00} :
		selMode ? modeRead :
		selStart ? startRead :
		selEdge ? {7'h00, edgeSel_r} :
		selIrq ? {6'h00, irqEn_r, irqReq_r} :
		selCkstp ? ckstp_r : 8'h00;

	// Bus answer registers
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= '0;
		end else begin
			pready_r <= apbAccess & ~pready_r;
			pslverr_r <= apbAccess & ~pready_r & ~mapped;
			prdata_r <= rdLoad ? {24'h000000, rdMux} : 32'h00000000;
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------

	// Mode register
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			mode_r <= '{speed: MODE_RST[MODE_SPEED_BIT], trigEn: MODE_RST[MODE_TRIG_BIT], chan: MODE_RST[3:0]};
		end else if (modeWr) begin
			mode_r <= '{speed: pwdata[MODE_SPEED_BIT], trigEn: pwdata[MODE_TRIG_BIT], chan: pwdata[3:0]};
		end
	end

	// Start flag: set by start, cleared by completion or stop
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			flag_r <= START_RST[START_FLAG_BIT];
		end else if (convStart) begin
			flag_r <= 1'b1;
		end else if (finish || swStop) begin
			flag_r <= 1'b0;
		end
	end

	// Clock stop, edge select and interrupt registers
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ckstp_r <= CKSTP_RST;
			edgeSel_r <= 1'b0;
			irqEn_r <= 1'b0;
		end else begin
			if (wrEn && selCkstp) begin
				ckstp_r <= pwdata[7:0];
			end
			if (wrEn && selEdge) begin
				edgeSel_r <= pwdata[EDGE_SEL_BIT];
			end
			if (wrEn && selIrq) begin
				irqEn_r <= pwdata[IRQ_EN_BIT];
			end
		end
	end

	// Request flag: completion wins over a software clear
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irqReq_r <= 1'b0;
			doneIrq_r <= 1'b0;
		end else begin
			if (finish) begin
				irqReq_r <= 1'b1;
			end else if (wrEn && selIrq && !pwdata[IRQ_REQ_BIT]) begin
				irqReq_r <= 1'b0;
			end
			doneIrq_r <= irqReq_r & irqEn_r;
		end
	end

	// Trigger history and channel select
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			trigPrev_r <= 1'b0;
			chanSel_r <= '0;
		end else begin
			trigPrev_r <= extTrigger;
			chanSel_r <= chanDecode(mode_r.chan);
		end
	end

	// Results: no reset, loaded only on normal completion
	always_ff @(posedge clock) begin
		if (finish) begin
			resHigh_r <= finalCode[RES_W-1:2];
			resLow_r <= finalCode[1:0];
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	sac_sar_engine engine (
		.clock(clock),
		.sys_rst(sys_rst),
		.start(convStart),
		.abort(swStop),
		.hold(standby),
		.fast(mode_r.speed),
		.compHigh(compHigh),
		.busy(engBusy),
		.finish(finish),
		.finalCode(finalCode),
		.ana(ana)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign chanSel = chanSel_r;
	assign sampleHold = ana.sampleHold;
	assign dacCode = ana.dac;
	assign moduleAwake = ckstp_r[CKSTP_ADC_BIT];
	assign doneIrq = doneIrq_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	mode_reset_a: assert property ($past(sys_rst) |-> modeRead == MODE_RST && startRead == START_RST)
		else $error("mode or start register reset value wrong");
	ckstp_reset_a: assert property ($past(sys_rst) |-> ckstp_r == CKSTP_RST)
		else $error("clock stop register reset value wrong");
	mode_fixed_a: assert property (rdLoad && selMode |=> prdata[5:4] == 2'b11)
		else $error("mode reserved bits not one");
	start_fixed_a: assert property (rdLoad && selStart |=> prdata[6:0] == 7'h7F)
		else $error("start reserved bits not one");
	result_load_a: assert property (finish |=> {resHigh_r, resLow_r} == $past(finalCode) && !flag_r)
		else $error("result not loaded with flag clear");
	result_hold_a: assert property (!finish |=> $stable(resHigh_r) && $stable(resLow_r))
		else $error("result changed outside completion");
	sequence trigSeen;
		trigStart;
	endsequence
	trig_start_a: assert property (trigSeen |=> flag_r && engBusy ##1 sampleHold)
		else $error("trigger edge did not start conversion");
	trig_off_a: assert property (!mode_r.trigEn && !startWr && !flag_r |=> !flag_r)
		else $error("start without enabled source");
	stop_quiet_a: assert property (swStop && !irqReq_r |=> !flag_r && !engBusy && !irqReq_r)
		else $error("stop left conversion running or raised request");
	chan_none_a: assert property (mode_r.chan[3:2] == 2'b00 |=> chanSel == 8'h00)
		else $error("channel selected for 00xx");
	standby_hold_a: assert property (standby |=> $stable(mode_r) && $stable(flag_r))
		else $error("register changed in standby");
	irq_out_a: assert property (finish && irqEn_r && !(wrEn && selIrq) |=> irqReq_r ##1 doneIrq)
		else $error("completion request not raised");

	// Bus answer shape
	ready_once_a: assert property (pready |=> !pready)
		else $error("ready stood longer than one cycle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	rdata_zero_a: assert property (!pready |-> prdata == 32'h00000000)
		else $error("read data outside answer cycle");

	// Register contents
	ckstp_write_a: assert property (wrEn && selCkstp |=> ckstp_r == $past(pwdata[7:0]))
		else $error("clock stop write lost");
	mode_write_a: assert property (modeWr |=> modeRead == ($past(pwdata[7:0]) | MODE_FIXED_ONES))
		else $error("mode write wrong");
	result_low_a: assert property (rdLoad && selResL |=> prdata[5:0] == 6'h00)
		else $error("low result unused bits not zero");
	chan_low_a: assert property (mode_r.chan[3:2] == 2'b01 |=> chanSel == 8'(8'h01 << $past(mode_r.chan[1:0])))
		else $error("lower input group select wrong");
	chan_high_a: assert property (mode_r.chan[3:2] == 2'b10 |=> chanSel == 8'(8'h10 << $past(mode_r.chan[1:0])))
		else $error("upper input group select wrong");

	// Conversion control
	flag_busy_a: assert property (flag_r == engBusy)
		else $error("start flag differs from sequencer state");
	start_flag_a: assert property (swStart |=> flag_r)
		else $error("software start did not set flag");
	sample_start_a: assert property (convStart |=> sampleHold && dacCode == '0)
		else $error("conversion did not open with sampling");
	trig_edge_a: assert property (trigStart |-> (edgeSel_r ? extTrigger : !extTrigger))
		else $error("trigger start on wrong edge");
	irq_set_a: assert property (finish |=> irqReq_r)
		else $error("completion did not set request");
	irq_masked_a: assert property (!irqEn_r |=> !doneIrq)
		else $error("masked request reached output");
	standby_stall_a: assert property (standby && engBusy |=> engBusy && $stable(dacCode) && $stable(sampleHold))
		else $error("sequencer moved in standby");

endmodule // sac_adc_control

// File: hdl/sac_pkg.sv
package sac_pkg;

	// ----------------------------------------
	// Bus geometry
	// ----------------------------------------
	localparam int ADDR_W = 18;
	localparam int DATA_W = 32;
	localparam int RES_W = 10;
	localparam int CHAN_N = 8;

	// ----------------------------------------
	// Register indices (byte address is four times these)
	// ----------------------------------------
	localparam logic [15:0] IDX_RES_HIGH = 16'hFFC4;
	localparam logic [15:0] IDX_RES_LOW = 16'hFFC5;
	localparam logic [15:0] IDX_MODE = 16'hFFC6;
	localparam logic [15:0] IDX_START = 16'hFFC7;
	localparam logic [15:0] IDX_TRIG_EDGE = 16'hFFC8;
	localparam logic [15:0] IDX_DONE_IRQ = 16'hFFC9;
	localparam logic [15:0] IDX_CKSTP1 = 16'hFFFA;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int MODE_SPEED_BIT = 7;
	localparam int MODE_TRIG_BIT = 6;
	localparam int START_FLAG_BIT = 7;
	localparam int CKSTP_ADC_BIT = 4;
	localparam int EDGE_SEL_BIT = 0;
	localparam int IRQ_REQ_BIT = 0;
	localparam int IRQ_EN_BIT = 1;

	// ----------------------------------------
	// Reset values and fixed read-as-one bits
	// ----------------------------------------
	localparam logic [7:0] MODE_RST = 8'h30;
	localparam logic [7:0] START_RST = 8'h7F;
	localparam logic [7:0] CKSTP_RST = 8'hFF;
	localparam logic [7:0] MODE_FIXED_ONES = 8'h30;
	localparam logic [7:0] START_FIXED_ONES = 8'h7F;

	// ----------------------------------------
	// Conversion timing in system clock cycles
	// ----------------------------------------
	localparam int CONV_SLOW_CYC = 62;
	localparam int CONV_FAST_CYC = 31;
	localparam int BIT_SLOW_CYC = 5;
	localparam int BIT_FAST_CYC = 2;
	localparam int SAMPLE_SLOW_CYC = CONV_SLOW_CYC - RES_W * BIT_SLOW_CYC;
	localparam int SAMPLE_FAST_CYC = CONV_FAST_CYC - RES_W * BIT_FAST_CYC;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		SAC_IDLE = 2'b00,
		SAC_SAMPLE = 2'b01,
		SAC_DECIDE = 2'b10
	} sac_state_t;

	typedef struct packed {
		logic speed;
		logic trigEn;
		logic [3:0] chan;
	} sac_mode_t;

	typedef struct packed {
		logic sampleHold;
		logic [RES_W-1:0] dac;
	} sac_ana_t;

	// Byte address of a register index
	function automatic logic [ADDR_W-1:0] addrOf(input logic [15:0] idx);
		return {idx, 2'b00};
	endfunction

	// Channel field to one-hot input select; 00xx selects none
	function automatic logic [CHAN_N-1:0] chanDecode(input logic [3:0] chan);
		logic [CHAN_N-1:0] sel;
		sel = 8'h00;
		if (chan[3:2] == 2'b01) begin
			sel[{1'b0, chan[1:0]}] = 1'b1;
		end else if (chan[3:2] == 2'b10) begin
			sel[{1'b1, chan[1:0]}] = 1'b1;
		end
		return sel;
	endfunction

endpackage

// File: hdl/sac_sar_engine.sv
`timescale 1ns/1ns
module sac_sar_engine import sac_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Control
	input wire logic start,
	input wire logic abort,
	input wire logic hold,
	input wire logic fast,
	// Comparator
	input wire logic compHigh,
	// Status and analog control
	output logic busy,
	output logic finish,
	output logic [RES_W-1:0] finalCode,
	output sac_ana_t ana
);

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	sac_state_t state_r;
	logic [5:0] cnt_r;
	logic [3:0] bitIdx_r;
	logic [RES_W-1:0] sar_r;
	logic fast_r;
	logic sh_r;
	logic [5:0] runCnt_r;

	// ----------------------------------------
	// Step lengths and status
	// ----------------------------------------
	wire logic [5:0] sampleLoad = fast ? 6'(SAMPLE_FAST_CYC - 1) : 6'(SAMPLE_SLOW_CYC - 1);
	wire logic [5:0] bitLoad = fast_r ? 6'(BIT_FAST_CYC - 1) : 6'(BIT_SLOW_CYC - 1);
	wire logic cntZero = (cnt_r == 6'h00);
	wire logic lastBit = (bitIdx_r == 4'h0);
	assign busy = (state_r != SAC_IDLE);
	assign finish = (state_r == SAC_DECIDE) && cntZero && lastBit && !hold && !abort;
	assign finalCode = {sar_r[RES_W-1:1], compHigh};
	assign ana = '{sampleHold: sh_r, dac: sar_r};

	// ----------------------------------------
	// Sample, then one decision per bit, MSB first
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_r <= SAC_IDLE;
			cnt_r <= 6'h00;
			bitIdx_r <= 4'h0;
			sar_r <= '0;
			fast_r <= 1'b0;
			sh_r <= 1'b0;
		end else if (abort) begin
			state_r <= SAC_IDLE;
			sh_r <= 1'b0;
		end else if (!hold) begin
			case (state_r)
				SAC_IDLE: begin
					if (start) begin
						state_r <= SAC_SAMPLE;
						cnt_r <= sampleLoad;
						fast_r <= fast;
						sar_r <= '0;
						sh_r <= 1'b1;
					end
				end
				SAC_SAMPLE: begin
					if (cntZero) begin
						state_r <= SAC_DECIDE;
						sh_r <= 1'b0;
						cnt_r <= bitLoad;
						bitIdx_r <= 4'(RES_W - 1);
						sar_r[RES_W-1] <= 1'b1;
					end else begin
						cnt_r <= cnt_r - 6'h01;
					end
				end
				SAC_DECIDE: begin
					if (!cntZero) begin
						cnt_r <= cnt_r - 6'h01;
					end else begin
						sar_r[bitIdx_r] <= compHigh;
						if (lastBit) begin
							state_r <= SAC_IDLE;
						end else begin
							bitIdx_r <= bitIdx_r - 4'h1;
							sar_r[bitIdx_r - 4'h1] <= 1'b1;
							cnt_r <= bitLoad;
						end
					end
				end
				default: state_r <= SAC_IDLE;
			endcase
		end
	end

	// Cycles since start, for the period check
	always_ff @(posedge clock) begin
		if (sys_rst || (start && !busy)) begin
			runCnt_r <= 6'h00;
		end else if (busy && !hold) begin
			runCnt_r <= runCnt_r + 6'h01;
		end
	end

	conv_period_a: assert property (finish |-> runCnt_r == (fast_r ? 6'(CONV_FAST_CYC - 1) : 6'(CONV_SLOW_CYC - 1)))
		else $error("conversion period wrong");

	sequence sampleEnds;
		(state_r == SAC_SAMPLE) && cntZero && !hold && !abort;
	endsequence
	msb_first_a: assert property (sampleEnds |=> bitIdx_r == 4'(RES_W - 1) && sar_r[RES_W-1] && !ana.sampleHold)
		else $error("decisions do not start at the top bit");

endmodule // sac_sar_engine

// File: verification/sac_analog_model.sv
`timescale 1ns/1ns
module sac_analog_model import sac_pkg::*; #(
	parameter logic [RES_W-1:0] LVL_BASE = 10'h05B,
	parameter logic [RES_W-1:0] LVL_STEP = 10'h07D
) (
	// Clock
	input wire logic clock,
	// Converter side
	input wire logic [CHAN_N-1:0] chanSel,
	input wire logic sampleHold,
	input wire logic [RES_W-1:0] dacCode,
	output logic compHigh
);
	// ----------------------------------------
	// Analog inputs and comparator
	// ----------------------------------------
	logic [RES_W:0] muxLvl;
	logic [RES_W:0] heldLvl = '0;

	// Input mux, half-LSB above each code; no channel reads as ground
	always_comb begin
		muxLvl = '0;
		for (int n = 0; n < CHAN_N; n++) begin
			if (chanSel[n]) begin
				muxLvl = {LVL_BASE + RES_W'(n) * LVL_STEP, 1'b1};
			end
		end
	end

	// Hold capacitor tracks only during sampling
	always @(posedge clock) begin
		if (sampleHold) begin
			heldLvl <= muxLvl;
		end
	end

	// Offset keeps the comparison from ever tying; ideal comparator, so no settling time to respect
	assign compHigh = heldLvl > {dacCode, 1'b0};
endmodule // sac_analog_model

// File: verification/sac_adc_control_tb.sv
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin numChecks++; if ((got) !== (exp)) begin miscompares++; \
	$display("BAD %s expected %h seen %h", nm, exp, got); end end
module sac_adc_control_tb import sac_pkg::*;;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam logic [RES_W-1:0] LVL_BASE = 10'h05B;
	localparam logic [RES_W-1:0] LVL_STEP = 10'h07D;
	localparam int CYC_LIMIT = 20000;
	logic clock = 1'b0;
	logic sysRst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [DATA_W-1:0] prdata;
	logic pready, pslverr, compHigh, sampleHold, moduleAwake, doneIrq;
	logic [CHAN_N-1:0] chanSel;
	logic [RES_W-1:0] dacCode;
	logic extTrigger = 1'b0;
	logic [7:0] rd;
	logic err;
	int miscompares = 0;
	int numChecks = 0;
	int cyc = 0;

	sac_adc_control dut (.clock(clock), .sys_rst(sysRst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.compHigh(compHigh), .chanSel(chanSel), .sampleHold(sampleHold), .dacCode(dacCode),
		.moduleAwake(moduleAwake), .extTrigger(extTrigger), .doneIrq(doneIrq));
	sac_analog_model #(.LVL_BASE(LVL_BASE), .LVL_STEP(LVL_STEP)) ana (.clock(clock), .chanSel(chanSel),
		.sampleHold(sampleHold), .dacCode(dacCode), .compHigh(compHigh));

	// Clock and hang guard
	always #10 clock = ~clock;
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == CYC_LIMIT) begin
			miscompares++;
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// Bus helpers
	// ----------------------------------------
	task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdChk(input string nm, input logic [15:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		`CHK(nm, exp, rd)
	endtask

	task automatic doReset;
		sysRst <= 1'b1;
		repeat (2) @(posedge clock);
		sysRst <= 1'b0;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_fields;
		logic [7:0] e;
		rdChk("mode reset", IDX_MODE, 8'h30);
		rdChk("start reset", IDX_START, 8'h7F);
		rdChk("clock stop reset", IDX_CKSTP1, 8'hFF);
		`CHK("awake at reset", 1'b1, moduleAwake)
		for (int c = 0; c < 16; c++) begin
			apb(1'b1, IDX_MODE, {4'h0, 4'(c)});
			rdChk("mode fixed ones", IDX_MODE, {4'h3, 4'(c)});
			e = 8'h00;
			if (c[3:2] == 2'b01) e = 8'h01 << c[1:0];
			else if (c[3:2] == 2'b10) e = 8'h10 << c[1:0];
			`CHK("channel select", e, chanSel)
		end
		apb(1'b1, IDX_MODE, 8'hC0);
		rdChk("speed and trigger bits", IDX_MODE, 8'hF0);
		apb(1'b1, IDX_START, 8'h00);
		rdChk("start fixed ones", IDX_START, 8'h7F);
	endtask

	// Full conversion, timed from start to interrupt when enabled, else checked for a masked interrupt
	task automatic convert(input logic speed, input int n, input logic en);
		int c0;
		logic [RES_W-1:0] lv;
		lv = LVL_BASE + RES_W'(n) * LVL_STEP;
		apb(1'b1, IDX_MODE, {speed, 3'b011, (n < 4) ? 2'b01 : 2'b10, 2'(n)});
		apb(1'b1, IDX_DONE_IRQ, {6'h00, en, 1'b0});
		apb(1'b1, IDX_START, 8'h80);
		c0 = cyc;
		#1;
		`CHK("sample at start", 1'b1, sampleHold)
		rdChk("flag while busy", IDX_START, 8'hFF);
		if (en) begin
			while (doneIrq !== 1'b1 && cyc < c0 + 200) begin
				@(posedge clock);
				#1;
			end
			`CHK("conversion period", speed ? 32 : 63, cyc - c0 - 1)
		end else begin
			repeat (70) @(posedge clock);
			#1;
			`CHK("masked irq", 1'b0, doneIrq)
		end
		rdChk("flag cleared", IDX_START, 8'h7F);
		rdChk("result high", IDX_RES_HIGH, lv[9:2]);
		rdChk("result low", IDX_RES_LOW, {lv[1:0], 6'h00});
		rdChk("request flag", IDX_DONE_IRQ, {6'h00, en, 1'b1});
	endtask

	// Abort mid-run, then reset keeps results
	task automatic t_stop;
		logic [7:0] hi;
		apb(1'b0, IDX_RES_HIGH, 8'h00);
		hi = rd;
		apb(1'b1, IDX_DONE_IRQ, 8'h02);
		apb(1'b1, IDX_START, 8'h80);
		repeat (10) @(posedge clock);
		apb(1'b1, IDX_START, 8'h00);
		rdChk("flag after stop", IDX_START, 8'h7F);
		repeat (70) @(posedge clock);
		#1;
		`CHK("no irq after stop", 1'b0, doneIrq)
		rdChk("no request after stop", IDX_DONE_IRQ, 8'h02);
		rdChk("result kept on stop", IDX_RES_HIGH, hi);
		apb(1'b1, IDX_RES_HIGH, ~hi);
		rdChk("result read only", IDX_RES_HIGH, hi);
		doReset();
		rdChk("result kept on reset", IDX_RES_HIGH, hi);
		rdChk("mode reset again", IDX_MODE, 8'h30);
	endtask

	// Trigger edge with chosen polarity and gate
	task automatic t_trig(input logic edgeSel, input logic en, input logic rise, input logic exp);
		apb(1'b1, IDX_MODE, 8'hB5);
		extTrigger <= ~rise;
		apb(1'b1, IDX_TRIG_EDGE, {7'h00, edgeSel});
		apb(1'b1, IDX_MODE, {1'b1, en, 6'h35});
		@(posedge clock);
		extTrigger <= rise;
		rdChk("trigger start", IDX_START, {exp, 7'h7F});
		repeat (40) @(posedge clock);
	endtask

	// Standby entered mid-conversion freezes it; leaving lets it finish
	task automatic t_standby;
		logic [RES_W-1:0] lv;
		lv = LVL_BASE + LVL_STEP;
		apb(1'b1, IDX_MODE, 8'hB5);
		apb(1'b1, IDX_START, 8'h80);
		apb(1'b1, IDX_CKSTP1, 8'hEF);
		rdChk("clock stop rw", IDX_CKSTP1, 8'hEF);
		`CHK("standby entered", 1'b0, moduleAwake)
		repeat (70) @(posedge clock);
		apb(1'b1, IDX_START, 8'h00);
		rdChk("start held in standby", IDX_START, 8'hFF);
		apb(1'b1, IDX_CKSTP1, 8'hFF);
		repeat (10) @(posedge clock);
		`CHK("standby left", 1'b1, moduleAwake)
		repeat (40) @(posedge clock);
		rdChk("finish after standby", IDX_START, 8'h7F);
		rdChk("result after standby", IDX_RES_HIGH, lv[9:2]);
		apb(1'b0, 16'hFFC0, 8'h00);
		`CHK("unmapped error", 1'b1, err)
		`CHK("unmapped data", 8'h00, rd)
	endtask

	// ----------------------------------------
	// Main sequence and verdict
	// ----------------------------------------
	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", numChecks, miscompares);
		if (miscompares == 0 && numChecks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		doReset();
		t_fields();
		convert(1'b0, 0, 1'b1);
		convert(1'b1, 7, 1'b0);
		convert(1'b1, 4, 1'b1);
		t_stop();
		t_trig(1'b1, 1'b0, 1'b1, 1'b0);
		t_trig(1'b1, 1'b1, 1'b1, 1'b1);
		t_trig(1'b0, 1'b1, 1'b1, 1'b0);
		t_trig(1'b0, 1'b1, 1'b0, 1'b1);
		t_standby();
		tally_and_finish();
	end
endmodule // sac_adc_control_tb
